// >>> rtl/dcspt_channel.v
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "dcspt_defs.vh"

// Notes on behaviour
// - source size register, 16 bits read/write, zero after reset
// - nonzero source size N means an N byte source
// - source size zero means 65,536 bytes
// - destination size register, 16 bits read/write, zero after reset
// - nonzero destination size N means an N byte destination
// - destination size zero means 65,536 bytes
// - source pointer is read-only and resets to zero
// - source pointer holds index of the byte now addressed
// - pattern match clears source pointer in pattern detect mode
// - destination pointer is read-only and resets to zero
// - destination pointer holds index of destination byte now addressed
// - upper sixteen bits of all four registers read zero
// - source done flag when source pointer reaches source size
// - source half flag when source pointer reaches half size
// - destination done and half-full flags likewise on destination side
// - block complete once the larger size has been moved
module dcspt_channel
(
    input wire mclk_in,
    input wire rst_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [5:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output wire wb_ack_out,
    output wire wb_err_out,
    input wire src_xfer_in,
    input wire [2:0] src_bytes_in,
    input wire dst_xfer_in,
    input wire [2:0] dst_bytes_in,
    input wire pattern_match_in,
    output wire enable_out,
    output wire pattern_mode_out,
    output wire busy_out,
    output wire irq_out
);
    reg [15:0] src_size_r;
    reg [15:0] dst_size_r;
    reg [1:0] ctrl_r;
    reg [4:0] irq_en_r;
    reg ack_r;
    reg err_r;
    reg [31:0] rdata_nxt;
    reg hit_nxt;

    wire [15:0] src_ptr;
    wire [15:0] dst_ptr;
    wire src_done;
    wire src_half;
    wire dst_done;
    wire dst_half;
    wire src_end;
    wire dst_end;
    wire [4:0] status;
    wire [4:0] set_vec;
    wire [4:0] clr_vec;
    wire req;
    wire wr;
    wire [3:0] idx;
    wire enable_rise;
    wire pattern_hit;
    wire block_done;
    wire ptr_clear;

    assign req = wb_cyc_in && wb_stb_in && !ack_r && !err_r;
    assign wr = req && wb_we_in;
    assign idx = wb_adr_in[5:2];

    // block ends when both sides are spent, i.e. the larger size is moved
    assign block_done = src_end && dst_end && ctrl_r[`DCSPT_CTRL_ENABLE];
    assign pattern_hit = pattern_match_in &&
        ctrl_r[`DCSPT_CTRL_PATTERN] && ctrl_r[`DCSPT_CTRL_ENABLE];
    assign enable_rise = wr && (idx == `DCSPT_OFS_CTRL) && wb_sel_in[0] &&
        wb_dat_in[`DCSPT_CTRL_ENABLE] && !ctrl_r[`DCSPT_CTRL_ENABLE];
    // the pointers restart after completion, a match, or a fresh enable
    assign ptr_clear = block_done || pattern_hit || enable_rise;

    always @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            src_size_r <= `DCSPT_RESET_VALUE;
            dst_size_r <= `DCSPT_RESET_VALUE;
            ctrl_r <= 2'h0;
            irq_en_r <= 5'h00;
        end
        else
        begin
            if (wr && idx == `DCSPT_OFS_SRC_SIZE)
            begin
                if (wb_sel_in[0])
                    src_size_r[7:0] <= wb_dat_in[7:0];
                if (wb_sel_in[1])
                    src_size_r[15:8] <= wb_dat_in[15:8];
            end
            if (wr && idx == `DCSPT_OFS_DST_SIZE)
            begin
                if (wb_sel_in[0])
                    dst_size_r[7:0] <= wb_dat_in[7:0];
                if (wb_sel_in[1])
                    dst_size_r[15:8] <= wb_dat_in[15:8];
            end
            if (wr && idx == `DCSPT_OFS_CTRL && wb_sel_in[0])
                ctrl_r <= wb_dat_in[1:0];
            else if (block_done && !ctrl_r[`DCSPT_CTRL_PATTERN])
                ctrl_r[`DCSPT_CTRL_ENABLE] <= 1'b0;
            if (wr && idx == `DCSPT_OFS_IRQ_EN && wb_sel_in[0])
                irq_en_r <= wb_dat_in[4:0];
        end
    end

    dcspt_side_track u_src
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .size_in(src_size_r),
        .step_in(src_bytes_in),
        .adv_in(src_xfer_in && ctrl_r[`DCSPT_CTRL_ENABLE]),
        .clear_in(ptr_clear),
        .ptr_out(src_ptr),
        .done_out(src_done),
        .half_out(src_half),
        .end_out(src_end)
    );

    dcspt_side_track u_dst
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .size_in(dst_size_r),
        .step_in(dst_bytes_in),
        .adv_in(dst_xfer_in && ctrl_r[`DCSPT_CTRL_ENABLE]),
        .clear_in(ptr_clear),
        .ptr_out(dst_ptr),
        .done_out(dst_done),
        .half_out(dst_half),
        .end_out(dst_end)
    );

    assign set_vec[`DCSPT_FLAG_SRC_DONE] = src_done;
    assign set_vec[`DCSPT_FLAG_SRC_HALF] = src_half;
    assign set_vec[`DCSPT_FLAG_DST_DONE] = dst_done;
    assign set_vec[`DCSPT_FLAG_DST_HALF] = dst_half;
    // a pattern match also counts as a block end
    assign set_vec[`DCSPT_FLAG_BLOCK] = block_done || pattern_hit;
    assign clr_vec = (wr && idx == `DCSPT_OFS_CLEAR && wb_sel_in[0]) ?
        wb_dat_in[4:0] : 5'h00;

    genvar g;
    generate
        for (g = 0; g < `DCSPT_FLAG_W; g = g + 1)
        begin : g_flag
            dcspt_flag_bit u_flag
            (
                .mclk_in(mclk_in),
                .rst_in(rst_in),
                .set_in(set_vec[g]),
                .clr_in(clr_vec[g]),
                .flag_out(status[g])
            );
        end
    endgenerate

    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        hit_nxt = 1'b1;
        case (idx)
            `DCSPT_OFS_SRC_SIZE: rdata_nxt = {16'h0000, src_size_r};
            `DCSPT_OFS_DST_SIZE: rdata_nxt = {16'h0000, dst_size_r};
            `DCSPT_OFS_SRC_PROG: rdata_nxt = {16'h0000, src_ptr};
            `DCSPT_OFS_DST_PROG: rdata_nxt = {16'h0000, dst_ptr};
            `DCSPT_OFS_CTRL: rdata_nxt = {30'h0000_0000, ctrl_r};
            `DCSPT_OFS_STATUS: rdata_nxt = {27'h000_0000, status};
            `DCSPT_OFS_CLEAR: rdata_nxt = 32'h0000_0000;
            `DCSPT_OFS_IRQ_EN: rdata_nxt = {27'h000_0000, irq_en_r};
            default: hit_nxt = 1'b0;
        endcase
    end

    // one wait state: data is registered, ack drops the cycle after
    always @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= req && hit_nxt;
            err_r <= req && !hit_nxt;
            wb_dat_out <= (req && hit_nxt && !wb_we_in) ?
                rdata_nxt : 32'h0000_0000;
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_err_out = err_r;
    assign enable_out = ctrl_r[`DCSPT_CTRL_ENABLE];
    assign pattern_mode_out = ctrl_r[`DCSPT_CTRL_PATTERN];
    assign busy_out = ctrl_r[`DCSPT_CTRL_ENABLE] && !block_done;
    assign irq_out = |(status & irq_en_r);
endmodule // dcspt_channel

// >>> rtl/dcspt_defs.vh
`ifndef DCSPT_DEFS_VH
`define DCSPT_DEFS_VH

// register word indices, taken from byte address bits 5:2
`define DCSPT_OFS_SRC_SIZE 4'h0
`define DCSPT_OFS_DST_SIZE 4'h1
`define DCSPT_OFS_SRC_PROG 4'h2
`define DCSPT_OFS_DST_PROG 4'h3
`define DCSPT_OFS_CTRL 4'h4
`define DCSPT_OFS_STATUS 4'h5
`define DCSPT_OFS_CLEAR 4'h6
`define DCSPT_OFS_IRQ_EN 4'h7

// control fields
`define DCSPT_CTRL_ENABLE 0
`define DCSPT_CTRL_PATTERN 1

// status / clear / enable fields
`define DCSPT_FLAG_SRC_DONE 4
`define DCSPT_FLAG_SRC_HALF 3
`define DCSPT_FLAG_DST_DONE 2
`define DCSPT_FLAG_DST_HALF 1
`define DCSPT_FLAG_BLOCK 0
`define DCSPT_FLAG_W 5

`define DCSPT_RESET_VALUE 16'h0000

`endif

// >>> rtl/dcspt_side_track.v
`timescale 1ns/1ps
// one side's byte pointer with done and half-way detection
module dcspt_side_track
(
    input wire mclk_in,
    input wire rst_in,
    input wire [15:0] size_in,
    input wire [2:0] step_in,
    input wire adv_in,
    input wire clear_in,
    output wire [15:0] ptr_out,
    output wire done_out,
    output wire half_out,
    output wire end_out
);
    reg [15:0] ptr_r;
    reg [16:0] bytes_r;
    reg done_seen_r;
    reg [16:0] bytes_nxt;
    wire [16:0] len;
    wire [16:0] half_len;

    // zero means the full 64 KiB span
    assign len = (size_in == 16'h0000) ? 17'h1_0000 : {1'b0, size_in};
    assign half_len = {1'b0, len[16:1]};

    always @*
    begin
        bytes_nxt = bytes_r + {14'h0000, step_in};
    end

    always @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ptr_r <= `DCSPT_RESET_VALUE;
            bytes_r <= 17'h0_0000;
            done_seen_r <= 1'b0;
        end
        else if (clear_in)
        begin
            ptr_r <= 16'h0000;
            bytes_r <= 17'h0_0000;
            done_seen_r <= 1'b0;
        end
        else if (adv_in && !done_seen_r)
        begin
            bytes_r <= bytes_nxt;
            ptr_r <= bytes_nxt[15:0];
            done_seen_r <= (bytes_nxt >= len);
        end
    end

    // pulses on the transfer that crosses each mark
    assign done_out = adv_in && !clear_in && !done_seen_r &&
        (bytes_nxt >= len) && (bytes_r < len);
    assign half_out = adv_in && !clear_in && !done_seen_r &&
        (bytes_nxt >= half_len) && (bytes_r < half_len);
    assign end_out = done_seen_r;
    assign ptr_out = ptr_r;
endmodule // dcspt_side_track

// >>> rtl/dcspt_flag_bit.v
`timescale 1ns/1ps
// sticky event bit; a new event beats a same-cycle clear
module dcspt_flag_bit
(
    input wire mclk_in,
    input wire rst_in,
    input wire set_in,
    input wire clr_in,
    output wire flag_out
);
    reg flag_r;

    always @(posedge mclk_in)
    begin
        if (rst_in)
            flag_r <= 1'b0;
        else if (set_in)
            flag_r <= 1'b1;
        else if (clr_in)
            flag_r <= 1'b0;
    end

    assign flag_out = flag_r;
endmodule // dcspt_flag_bit

// >>> testbench/dcspt_props.sv
`timescale 1ns/1ps
module dcspt_props
(
    input wire mclk_in,
    input wire rst_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [5:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out,
    input wire wb_err_out,
    input wire enable_out,
    input wire pattern_mode_out,
    input wire busy_out,
    input wire irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    wire req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
    AST_ACK_NEXT:
        assert property (req && !wb_adr_in[5] |=> wb_ack_out && !wb_err_out)
        else $error("mapped request not answered next cycle");
    AST_ERR_NEXT:
        assert property (req && wb_adr_in[5] |=> wb_err_out && !wb_ack_out)
        else $error("unmapped request not refused next cycle");
    AST_ACK_PULSE:
        assert property (wb_ack_out |=> !wb_ack_out ##1 !wb_ack_out)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE:
        assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
        else $error("read data outside ack cycle");
    AST_UPPER_ZERO:
        assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0000)
        else $error("upper half of read data not zero");
    AST_EN_WRITE:
        assert property (req && wb_we_in && wb_adr_in[5:2] == 4'h4
            && wb_sel_in[0] && !enable_out
            |=> enable_out == $past(wb_dat_in[0]))
        else $error("enable does not follow control write");
    AST_RST_CLEAR:
        assert property ($fell(rst_in) |-> !irq_out && !enable_out)
        else $error("state not cleared by reset");
    AST_BUSY_EN:
        assert property (busy_out |-> enable_out)
        else $error("busy while disabled");
    AST_BLOCK_STOP:
        assert property (enable_out && !busy_out && !pattern_mode_out
            && !(req && wb_we_in && wb_adr_in[5:2] == 4'h4 && wb_sel_in[0])
            |=> !enable_out)
        else $error("enable kept after block end");
    AST_MODE_WRITE:
        assert property (req && wb_we_in && wb_adr_in[5:2] == 4'h4
            && wb_sel_in[0] |=> pattern_mode_out == $past(wb_dat_in[1]))
        else $error("pattern mode does not follow control write");
endmodule // dcspt_props

bind dcspt_channel dcspt_props u_props (.mclk_in(mclk_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .wb_err_out(wb_err_out), .enable_out(enable_out),
    .pattern_mode_out(pattern_mode_out),
    .busy_out(busy_out), .irq_out(irq_out));

// >>> testbench/dcspt_mover.sv
`timescale 1ns/1ps
// bus mover model: n transfers per side, gap idle cycles between them
module dcspt_mover
(
    input wire mclk_in,
    output reg src_xfer_out = 1'b0,
    output reg [2:0] src_bytes_out = 3'h0,
    output reg dst_xfer_out = 1'b0,
    output reg [2:0] dst_bytes_out = 3'h0,
    output reg match_out = 1'b0
);
    // idle byte counts are scrambled so nothing leans on a stale value
    task drop;
        src_xfer_out <= 1'b0;
        dst_xfer_out <= 1'b0;
        src_bytes_out <= ~src_bytes_out;
        dst_bytes_out <= ~dst_bytes_out;
    endtask
    task run(input int n, input [2:0] sb, input [2:0] db, input int gap);
        int i;
        for (i = 0; i < n; i++)
        begin
            @(posedge mclk_in);
            src_xfer_out <= sb != 3'h0;
            src_bytes_out <= sb;
            dst_xfer_out <= db != 3'h0;
            dst_bytes_out <= db;
            if (gap > 0)
            begin
                @(posedge mclk_in);
                drop();
                repeat (gap - 1) @(posedge mclk_in);
            end
        end
        @(posedge mclk_in);
        drop();
    endtask
    task hit;
        @(posedge mclk_in);
        match_out <= 1'b1;
        @(posedge mclk_in);
        match_out <= 1'b0;
    endtask
endmodule // dcspt_mover

// >>> testbench/dcspt_channel_tb.sv
`timescale 1ns/1ps
module dcspt_channel_tb;
    reg mclk_in = 1'b0;
    reg rst_in = 1'b1;
    reg cyc = 1'b0, stb = 1'b0, we = 1'b0, er;
    reg [5:0] adr = 6'h00;
    reg [3:0] sel = 4'h0;
    reg [31:0] wdat = 32'h0000_0000, rd;
    wire [31:0] rdat;
    wire ack, err, sx, dx, pm, en, busy, irq;
    wire [2:0] sb, db;
    integer n_errors = 0, n_compared = 0, k;
    dcspt_channel uut (.mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .wb_err_out(err), .src_xfer_in(sx), .src_bytes_in(sb),
        .dst_xfer_in(dx), .dst_bytes_in(db), .pattern_match_in(pm),
        .enable_out(en), .pattern_mode_out(), .busy_out(busy),
        .irq_out(irq));
    dcspt_mover mv (.mclk_in(mclk_in), .src_xfer_out(sx),
        .src_bytes_out(sb), .dst_xfer_out(dx), .dst_bytes_out(db),
        .match_out(pm));
    initial
    begin
        forever #50 mclk_in = ~mclk_in;
    end
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task wb(input w, input [3:0] i, input [3:0] s, input [31:0] d);
        @(posedge mclk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= s;
        wdat <= d;
        @(posedge mclk_in);
        while (!(ack | err)) @(posedge mclk_in);
        rd = rdat;
        er = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rc(input [3:0] i, input [31:0] e, input string nm);
        wb(1'b0, i, 4'hF, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    initial
    begin
        #4_000_000;
        n_errors = n_errors + 1;
        report_and_stop;
    end
    initial
    begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (k = 0; k < 8; k++)
            if (k != 6) rc(k[3:0], 32'h0000_0000, "reset value");
        wb(1'b1, 4'h0, 4'hF, 32'hFFFF_1234);
        wb(1'b1, 4'h0, 4'h1, 32'h0000_00AB);
        rc(4'h0, 32'h0000_12AB, "src size");
        wb(1'b1, 4'h1, 4'hF, 32'hFFFF_0004);
        rc(4'h1, 32'h0000_0004, "dst size");
        wb(1'b1, 4'h2, 4'hF, 32'h0000_FFFF);
        rc(4'h2, 32'h0000_0000, "src ptr write");
        wb(1'b1, 4'h3, 4'hF, 32'h0000_FFFF);
        rc(4'h3, 32'h0000_0000, "dst ptr write");
        wb(1'b0, 4'h8, 4'hF, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0, er});
        $display("test registers ended");
        wb(1'b1, 4'h0, 4'hF, 32'h0000_0008);
        wb(1'b1, 4'h7, 4'hF, 32'h0000_001F);
        wb(1'b1, 4'h4, 4'hF, 32'h0000_0001);
        mv.run(2, 3'h2, 3'h1, 2);
        rc(4'h2, 32'h0000_0004, "src ptr");
        rc(4'h3, 32'h0000_0002, "dst ptr");
        rc(4'h5, 32'h0000_000A, "half flags");
        chk("irq on half", 32'h0000_0001, {31'h0, irq});
        mv.run(2, 3'h2, 3'h1, 0);
        rc(4'h5, 32'h0000_001F, "done flags");
        rc(4'h2, 32'h0000_0000, "ptr after block");
        rc(4'h4, 32'h0000_0000, "enable after block");
        wb(1'b1, 4'h7, 4'hF, 32'h0000_0000);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        wb(1'b1, 4'h7, 4'hF, 32'h0000_001F);
        wb(1'b1, 4'h6, 4'hF, 32'h0000_001F);
        rc(4'h5, 32'h0000_0000, "status cleared");
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        $display("test small block ended");
        // size zero means the full 65536 bytes on both sides
        wb(1'b1, 4'h0, 4'hF, 32'h0000_0000);
        wb(1'b1, 4'h1, 4'hF, 32'h0000_0000);
        wb(1'b1, 4'h4, 4'hF, 32'h0000_0001);
        mv.run(8192, 3'h4, 3'h4, 0);
        rc(4'h2, 32'h0000_8000, "src ptr mid");
        rc(4'h5, 32'h0000_000A, "half of full");
        mv.run(8192, 3'h4, 3'h4, 0);
        rc(4'h5, 32'h0000_001F, "done at full");
        wb(1'b1, 4'h6, 4'hF, 32'h0000_001F);
        $display("test full size ended");
        wb(1'b1, 4'h0, 4'hF, 32'h0000_0010);
        wb(1'b1, 4'h1, 4'hF, 32'h0000_0010);
        wb(1'b1, 4'h4, 4'hF, 32'h0000_0003);
        mv.run(3, 3'h2, 3'h2, 1);
        rc(4'h2, 32'h0000_0006, "src ptr before match");
        mv.hit();
        rc(4'h2, 32'h0000_0000, "src ptr on match");
        rc(4'h5, 32'h0000_0001, "match flag");
        rc(4'h4, 32'h0000_0003, "still enabled");
        mv.run(1, 3'h2, 3'h2, 0);
        wb(1'b1, 4'h4, 4'hF, 32'h0000_0001);
        mv.hit();
        rc(4'h2, 32'h0000_0002, "src ptr match ignored");
        wb(1'b1, 4'h4, 4'hF, 32'h0000_0000);
        wb(1'b1, 4'h4, 4'hF, 32'h0000_0001);
        rc(4'h2, 32'h0000_0000, "src ptr on enable");
        $display("test pattern ended");
        // reset in mid-run must wipe pointers, sizes and sticky flags
        mv.run(1, 3'h2, 3'h2, 0);
        rc(4'h3, 32'h0000_0002, "dst ptr before reset");
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        rc(4'h3, 32'h0000_0000, "dst ptr after reset");
        rc(4'h0, 32'h0000_0000, "src size after reset");
        rc(4'h1, 32'h0000_0000, "dst size after reset");
        rc(4'h5, 32'h0000_0000, "status after reset");
        rc(4'h4, 32'h0000_0000, "ctrl after reset");
        $display("test reset ended");
        report_and_stop;
    end
endmodule // dcspt_channel_tb
